// ### dcod_core.sv
// Condition evaluation and operand decode for a fixed-point DSP core.
// Assumes requests and bus strobes come from logic on sys_clk; the branch
// pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
module dcod_core
	import dcod_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire dcod_req_t             req,
	output dcod_res_t                  res,
	input  wire logic [DCOD_RAW-1:0]   reg_addr,
	input  wire logic [DCOD_DW-1:0]    reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [DCOD_DW-1:0]         reg_rdata,
	input  wire logic                  branch_input_pin,
	output logic [DCOD_DW-1:0]         sum_upper_half,
	output logic [DCOD_DW-1:0]         sum_lower_half
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [31:0]      main_sum_word;
		logic             carry;
		logic             overflow;
		logic             test_control_flag;
		logic [2:0]       index_reg_pointer;
		logic [2:0]       prior_index_pointer;
		logic [8:0]       page;
		logic [7:0][15:0] aux;
		logic [2:0]       pin_sync;
		logic             pin_level;
		dcod_res_t        res;
		logic [15:0]      rdata;
	} dcod_state_t;

	dcod_state_t q;
	dcod_state_t d;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic cond_eval(input logic [7:0] f, input logic z, input logic n,
		input logic v, input logic c);
		logic [3:0] m;
		logic [3:0] s;
		logic       ok;
		m  = f[DCOD_MASK_LO +: 4];                                  // RQ1
		s  = f[DCOD_STATE_LO +: 4];                                 // RQ2
		ok = 1'b1;                                                  // RQ13
		// Zero and negative selected together form one signed compare
		if (m[DCOD_Z_BIT] && m[DCOD_L_BIT]) begin
			ok = (s[DCOD_Z_BIT] && z) || (!z && (n == s[DCOD_L_BIT]));  // RQ4
		end else begin
			if (m[DCOD_Z_BIT] && (z != s[DCOD_Z_BIT])) begin         // RQ3
				ok = 1'b0;
			end
			if (m[DCOD_L_BIT] && (n != s[DCOD_L_BIT])) begin         // RQ3
				ok = 1'b0;
			end
		end
		if (m[DCOD_V_BIT] && (v != s[DCOD_V_BIT])) begin             // RQ3
			ok = 1'b0;
		end
		if (m[DCOD_C_BIT] && (c != s[DCOD_C_BIT])) begin             // RQ3
			ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic tp_eval(input logic [1:0] tp, input logic pin, input logic tf);
		case (tp)                                                   // RQ12
			DCOD_TP_PIN_LOW:  return !pin;
			DCOD_TP_FLAG_SET: return tf;
			DCOD_TP_FLAG_CLR: return !tf;
			default:          return 1'b1;
		endcase
	endfunction

	function automatic logic [15:0] data_address(input logic [15:0] w,
		input dcod_state_t st);
		// Indirect goes through the current index register
		if (w[DCOD_IND_BIT]) begin
			return st.aux[st.index_reg_pointer];
		end
		return {st.page, w[DCOD_DMA_LO +: 7]};                       // RQ9 RQ11
	endfunction

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic zero;
		logic neg;
		zero = 1'b0;
		neg  = 1'b0;
		d = q;
		// First stage feeds only the second; a change counts when 2 and 3 agree
		d.pin_sync = {q.pin_sync[1:0], branch_input_pin};
		if (q.pin_sync[1] == q.pin_sync[2]) begin
			d.pin_level = q.pin_sync[2];
		end
		d.res.valid = 1'b0;
		d.rdata     = 16'h0000;

		if (reg_rd) begin
			case (reg_addr)
				DCOD_REG_SUM_HI: d.rdata = q.main_sum_word[31:16];      // RQ6
				DCOD_REG_SUM_LO: d.rdata = q.main_sum_word[15:0];       // RQ6
				DCOD_REG_FLAGS: begin
					d.rdata[DCOD_FLG_CARRY] = q.carry;
					d.rdata[DCOD_FLG_OVF]   = q.overflow;
					d.rdata[DCOD_FLG_TEST]  = q.test_control_flag;
				end
				DCOD_REG_PTR:    d.rdata[2:0] = q.index_reg_pointer;
				DCOD_REG_PRIOR:  d.rdata[2:0] = q.prior_index_pointer;
				DCOD_REG_PAGE:   d.rdata[8:0] = q.page;
				DCOD_REG_STATUS: begin
					d.rdata[DCOD_STS_MET] = q.res.cond_met;
					d.rdata[DCOD_STS_PIN] = q.pin_level;
				end
				default: begin
					if (reg_addr[3]) begin
						d.rdata = q.aux[reg_addr[2:0]];
					end
				end
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
				DCOD_REG_SUM_HI: d.main_sum_word[31:16] = reg_wdata;    // RQ6
				DCOD_REG_SUM_LO: d.main_sum_word[15:0]  = reg_wdata;    // RQ6
				DCOD_REG_FLAGS: begin
					d.carry             = reg_wdata[DCOD_FLG_CARRY];
					d.overflow          = reg_wdata[DCOD_FLG_OVF];
					d.test_control_flag = reg_wdata[DCOD_FLG_TEST];
				end
				DCOD_REG_PTR: begin
					d.prior_index_pointer = q.index_reg_pointer;        // RQ7
					d.index_reg_pointer   = reg_wdata[2:0];
				end
				DCOD_REG_PAGE: d.page = reg_wdata[8:0];
				default: begin
					if (reg_addr[3]) begin
						d.aux[reg_addr[2:0]] = reg_wdata;
					end
				end
			endcase
		end

		// Decode sees the sum as it stood before any write in this cycle
		zero = (q.main_sum_word == 32'h0000_0000);
		neg  = q.main_sum_word[31];
		if (req.valid) begin
			d.res.valid = 1'b1;
			case (req.kind)
				DCOD_KIND_COND: begin
					d.res.cond_met = cond_eval(req.word0[7:0], zero, neg, q.overflow, q.carry)
						&& tp_eval(req.word0[DCOD_TP_LO +: 2], q.pin_level,
						q.test_control_flag);
				end
				DCOD_KIND_DIRECT: begin
					d.res.data_addr = data_address(req.word0, q);
				end
				DCOD_KIND_BITTEST: begin
					d.res.data_addr  = data_address(req.word0, q);
					d.res.bit_select = 16'h0001 << req.word0[DCOD_BITC_LO +: 4];  // RQ10
				end
				DCOD_KIND_PTR: begin
					// A request overrides a same-cycle bus write to the pointer
					d.prior_index_pointer = q.index_reg_pointer;        // RQ7
					d.index_reg_pointer   = req.word0[DCOD_NEXT_LO +: 3];  // RQ8
				end
				DCOD_KIND_LONG: begin
					d.res.long_const = req.word1;                       // RQ5
				end
				default: begin
					d.res.valid = 1'b0;
				end
			endcase
		end
		d.res.index_reg_pointer = d.index_reg_pointer;
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign res            = q.res;
	assign reg_rdata      = q.rdata;
	assign sum_upper_half = q.main_sum_word[31:16];                     // RQ6
	assign sum_lower_half = q.main_sum_word[15:0];                      // RQ6

endmodule

// ### dcod_pkg.sv
// Constants, field layouts and carrier types of the condition and operand decoder.
// Assumes one core clock; software reaches the registers over a plain strobe port.
// ----------------------------------------------------------------------------
// Notes on behaviour
// [RQ1] Low condition nibble is a mask; a set bit selects that condition for testing.
// [RQ2] Upper condition nibble, bits 4 to 7, gives the required state of each condition.
// [RQ3] Nibble bit order is zero, negative, overflow, carry.
// [RQ4] Mask with zero and negative set, others clear, tests non-negative sum.
// [RQ5] Two-word opcodes carry a 16-bit constant in their second word.
// [RQ6] Sum word is exposed as upper half 31..16 and lower half 15..0.
// [RQ7] Any change of the index pointer saves its old value as prior pointer.
// [RQ8] A named next index register, 0 to 7, is loaded into the pointer.
// [RQ9] Direct addressing uses the short field as the seven low address bits.
// [RQ10] A 4-bit bit code picks which single data bit the bit test examines.
// [RQ11] Full data memory addresses are 16 bits wide.
// [RQ12] Pin condition: 00 pin low, 01 flag set, 10 flag clear, 11 none.
// [RQ13] Met only when all selected conditions match; empty mask is always met (code still ANDs in the pin condition unless it is 11,
// and tests zero and negative together as one signed compare when both are masked).
// ----------------------------------------------------------------------------
package dcod_pkg;

	// ------------------------------------------------------------------------
	// Widths and register offsets
	// ------------------------------------------------------------------------
	localparam int DCOD_DW  = 16;
	localparam int DCOD_RAW = 4;
	localparam logic [3:0] DCOD_REG_SUM_HI  = 4'h0;
	localparam logic [3:0] DCOD_REG_SUM_LO  = 4'h1;
	localparam logic [3:0] DCOD_REG_FLAGS   = 4'h2;
	localparam logic [3:0] DCOD_REG_PTR     = 4'h3;
	localparam logic [3:0] DCOD_REG_PRIOR   = 4'h4;
	localparam logic [3:0] DCOD_REG_PAGE    = 4'h5;
	localparam logic [3:0] DCOD_REG_STATUS  = 4'h6;
	localparam logic [3:0] DCOD_REG_AUX_LO  = 4'h8;

	// ------------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------------
	localparam int DCOD_FLG_CARRY = 0;
	localparam int DCOD_FLG_OVF   = 1;
	localparam int DCOD_FLG_TEST  = 2;
	localparam int DCOD_STS_MET   = 0;
	localparam int DCOD_STS_PIN   = 1;
	localparam int DCOD_MASK_LO   = 0;
	localparam int DCOD_STATE_LO  = 4;
	localparam int DCOD_TP_LO     = 8;
	localparam int DCOD_IND_BIT   = 7;
	localparam int DCOD_DMA_LO    = 0;
	localparam int DCOD_BITC_LO   = 8;
	localparam int DCOD_NEXT_LO   = 0;
	localparam int DCOD_C_BIT     = 0;
	localparam int DCOD_V_BIT     = 1;
	localparam int DCOD_L_BIT     = 2;
	localparam int DCOD_Z_BIT     = 3;

	// ------------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------------
	localparam logic [1:0] DCOD_TP_PIN_LOW   = 2'h0;
	localparam logic [1:0] DCOD_TP_FLAG_SET  = 2'h1;
	localparam logic [1:0] DCOD_TP_FLAG_CLR  = 2'h2;
	localparam logic [1:0] DCOD_TP_NONE      = 2'h3;
	localparam logic [2:0] DCOD_KIND_COND    = 3'h1;
	localparam logic [2:0] DCOD_KIND_DIRECT  = 3'h2;
	localparam logic [2:0] DCOD_KIND_BITTEST = 3'h3;
	localparam logic [2:0] DCOD_KIND_PTR     = 3'h4;
	localparam logic [2:0] DCOD_KIND_LONG    = 3'h5;

	// ------------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic [2:0]  kind;
		logic [15:0] word0;
		logic [15:0] word1;
	} dcod_req_t;

	typedef struct packed {
		logic        valid;
		logic        cond_met;
		logic [15:0] data_addr;
		logic [15:0] bit_select;
		logic [15:0] long_const;
		logic [2:0]  index_reg_pointer;
	} dcod_res_t;

endpackage

// ### dcod_chk.sv
// Concurrent checks on the ports of the condition and operand decoder.
// Assumes no bus write lands in the same cycle as a decode request.
`timescale 1ns/10ps
module dcod_chk
	import dcod_pkg::*;
(
	input wire logic                sys_clk,
	input wire logic                sys_rst,
	input wire dcod_req_t           req,
	input wire dcod_res_t           res,
	input wire logic [DCOD_RAW-1:0] reg_addr,
	input wire logic [DCOD_DW-1:0]  reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [DCOD_DW-1:0]  reg_rdata,
	input wire logic                branch_input_pin,
	input wire logic [DCOD_DW-1:0]  sum_upper_half,
	input wire logic [DCOD_DW-1:0]  sum_lower_half
);
	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic cnd;
	assign cnd = req.valid && req.kind == DCOD_KIND_COND;
	chk_empty_mask_met: assert property (
		cnd && req.word0[9:0] == 10'h300 |=> res.valid && res.cond_met)
		else $error("empty mask not met");
	chk_non_negative: assert property (
		cnd && req.word0[9:0] == 10'h38c |=> res.cond_met == !$past(sum_upper_half[15]))
		else $error("non-negative test wrong");
	chk_zero_state: assert property (
		cnd && req.word0[9:0] == 10'h388 |=> res.cond_met ==
		($past(sum_upper_half) == 16'h0000 && $past(sum_lower_half) == 16'h0000))
		else $error("zero test wrong");
	chk_long_word: assert property (
		req.valid && req.kind == DCOD_KIND_LONG |=> res.valid &&
		res.long_const == $past(req.word1))
		else $error("long constant wrong");
	chk_ptr_load: assert property (
		req.valid && req.kind == DCOD_KIND_PTR |=>
		res.index_reg_pointer == $past(req.word0[2:0]))
		else $error("pointer load wrong");
	chk_bit_pick: assert property (
		req.valid && req.kind == DCOD_KIND_BITTEST |=> $onehot(res.bit_select) &&
		res.bit_select == (16'h0001 << $past(req.word0[11:8])))
		else $error("bit select wrong");
	chk_direct_low: assert property (
		req.valid && req.kind == DCOD_KIND_DIRECT && !req.word0[7] |=>
		res.data_addr[6:0] == $past(req.word0[6:0]))
		else $error("direct address wrong");
	chk_upper_half: assert property (
		reg_wr && reg_addr == DCOD_REG_SUM_HI |=> sum_upper_half == $past(reg_wdata))
		else $error("upper half wrong");
	chk_lower_half: assert property (
		reg_wr && reg_addr == DCOD_REG_SUM_LO |=> sum_lower_half == $past(reg_wdata))
		else $error("lower half wrong");
	cov_cond_met: cover property (cnd ##1 res.cond_met);
	cov_prior_read: cover property (reg_rd && reg_addr == DCOD_REG_PRIOR);
	cov_ptr_load: cover property (req.valid && req.kind == DCOD_KIND_PTR);
endmodule

bind dcod_core dcod_chk dcod_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .res(res),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .branch_input_pin(branch_input_pin),
	.sum_upper_half(sum_upper_half), .sum_lower_half(sum_lower_half));

// ### test_dsp_condition_operand_decode.sv
// Self-checking bench for the condition and operand decoder.
// Assumes the checker is bound to the core; the pin is held steady before a test.
`timescale 1ns/10ps
module test_dsp_condition_operand_decode
	import dcod_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	dcod_req_t   req = '0;
	dcod_res_t   res;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        branch_input_pin = 1'b0;
	logic [15:0] sum_hi;
	logic [15:0] sum_lo;
	int          errors = 0;
	int          n_compared = 0;
	logic [18:0] qr [$];
	logic [15:0] qb [$];
	logic [31:0] r = 32'h0000_de2c;
	logic        rd_seen = 1'b0;
	logic [15:0] fix [3] = '{16'h0300, 16'h038c, 16'h0388};

	always #20 sys_clk = ~sys_clk;

	dcod_core dcod_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .res(res),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .branch_input_pin(branch_input_pin),
		.sum_upper_half(sum_hi), .sum_lower_half(sum_lo));

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function logic [31:0] nx();
		r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
		return r;
	endfunction

	// Met state when zero and negative are both masked follows the chosen ordering rule
	function logic ec(input logic [15:0] w, input logic [31:0] s, input logic [2:0] f,
		input logic p);
		logic [3:0] c;
		logic       m;
		c = {s == 32'h0000_0000, s[31], f[1], f[0]};
		if (w[3] && w[2]) m = (w[7] & c[3]) | (!c[3] & (c[2] == w[6]));
		else m = ((c ^ w[7:4]) & w[3:0]) == 4'h0;
		case (w[9:8])
			2'h0: m = m & !p;
			2'h1: m = m & f[2];
			2'h2: m = m & !f[2];
			default: m = m;
		endcase
		return m;
	endfunction

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		qb.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	// Unknown kinds get no note, so any answer to them shows as a mismatch
	task rq(input logic [2:0] k, input logic [15:0] w0, input logic [15:0] w1,
		input logic [15:0] e);
		@(posedge sys_clk);
		req <= '{1'b1, k, w0, w1};
		if (k inside {[3'h1:3'h5]}) qr.push_back({k, e});
		@(posedge sys_clk);
		req.valid <= 1'b0;
	endtask

	task report_and_stop();
		if (qr.size() != 0 || qb.size() != 0) errors++;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Monitor and stimulus
	// ------------------------------------------------------------------------
	always @(posedge sys_clk) begin
		logic [18:0] e;
		if (rd_seen) chk(reg_rdata, qb.pop_front());
		rd_seen = reg_rd;
		if (res.valid !== 1'b0 && !sys_rst) begin
			if (qr.size() == 0) chk({15'h0000, res.valid}, 16'h0000);
			else begin
				e = qr.pop_front();
				case (e[18:16])
					DCOD_KIND_COND: chk({15'h0000, res.cond_met}, e[15:0]);
					DCOD_KIND_DIRECT: chk(res.data_addr, e[15:0]);
					DCOD_KIND_BITTEST: chk(res.bit_select, e[15:0]);
					DCOD_KIND_PTR: chk({13'h0000, res.index_reg_pointer}, e[15:0]);
					default: chk(res.long_const, e[15:0]);
				endcase
			end
		end
	end

	initial begin
		#200000;
		errors++;
		report_and_stop();
	end

	initial begin
		logic [31:0] s;
		logic [31:0] w;
		logic [15:0] p;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(DCOD_REG_PTR, 16'(7 - i));
			rq(DCOD_KIND_PTR, 16'(i), 16'h0000, 16'(i));
			rd(DCOD_REG_PRIOR, 16'(7 - i));
		end
		wr(DCOD_REG_PRIOR, 16'h0005);
		rd(DCOD_REG_PRIOR, 16'h0000);
		wr(4'h7, 16'hffff);
		rd(4'h7, 16'h0000);
		for (int c = 0; c < 16; c++) rq(DCOD_KIND_BITTEST, 16'(c << 8), 16'h0000, 16'(1 << c));
		p = 16'(nx()) & 16'h01ff;
		wr(DCOD_REG_PAGE, p);
		for (int i = 0; i < 8; i++) begin
			w = nx() & 32'h0000_007f;
			rq(DCOD_KIND_DIRECT, w[15:0], 16'h0000, {p[8:0], w[6:0]});
		end
		for (int i = 0; i < 4; i++) begin
			w = nx();
			rq(DCOD_KIND_LONG, 16'h0000, w[15:0], w[15:0]);
		end
		for (int k = 0; k < 8; k += 6) rq(3'(k), 16'h0000, 16'h1234, 16'h0000);
		rq(3'h7, 16'h0000, 16'h1234, 16'h0000);
		for (int i = 0; i < 24; i++) begin
			s = nx();
			if (s[4:3] == 2'h0) s = 32'h0000_0000;
			w = nx();
			if (i < 9) w[15:0] = {w[15:10], fix[i % 3][9:0]};
			if (w[3] && w[2]) w[1:0] = 2'h0;
			wr(DCOD_REG_SUM_HI, s[31:16]);
			wr(DCOD_REG_SUM_LO, s[15:0]);
			rd(DCOD_REG_SUM_HI, s[31:16]);
			chk(sum_hi, s[31:16]);
			chk(sum_lo, s[15:0]);
			wr(DCOD_REG_FLAGS, {13'h0000, w[22:20]});
			branch_input_pin <= w[12];
			repeat (4) @(posedge sys_clk);
			rq(DCOD_KIND_COND, w[15:0], 16'h0000, {15'h0000, ec(w[15:0], s, w[22:20], w[12])});
		end
		repeat (4) @(posedge sys_clk);
		report_and_stop();
	end
endmodule
